// ### hdl/manual_value_store.sv
// Small store of the manipulated values from the last manual session
`timescale 1ns/1ns
module manual_value_store
  import start_mode_pkg::*;
#(
  parameter int WIDTH = VALUE_W,                   // Bits per value
  parameter int DEPTH = MV_CH                      // Number of channels
) (
  input  wire logic                     clock,
  input  wire logic                     reset,
  input  wire logic                     write_en,
  input  wire logic [DEPTH*WIDTH-1:0]   write_data,
  output logic      [DEPTH*WIDTH-1:0]   read_data
);

  // ==========
  // Storage, one entry per channel
  logic [WIDTH-1:0] mem_reg [DEPTH];               // Remembered manual values

  genvar ch;
  generate
    for (ch = 0; ch < DEPTH; ch++) begin : g_entry
      // Entry written while manual mode runs
      always_ff @(posedge clock) begin
        if (reset) begin
          mem_reg[ch] <= '0;
        end else if (write_en) begin
          mem_reg[ch] <= write_data[ch*WIDTH +: WIDTH];
        end
      end

      // Registered read port
      always_ff @(posedge clock) begin
        if (reset) begin
          read_data[ch*WIDTH +: WIDTH] <= '0;
        end else begin
          read_data[ch*WIDTH +: WIDTH] <= mem_reg[ch];
        end
      end
    end
  endgenerate

endmodule // manual_value_store

// ### hdl/start_mode_pkg.sv
// Constants and types shared by the start and mode transfer logic
package start_mode_pkg;

  // ==========
  // Value widths
  localparam int VALUE_W = 16;                     // Width of measured, set and manipulated values
  localparam int ADDR_W  = 5;                      // Width of a second-port address
  localparam int MV_CH   = 2;                      // Manipulated value channels (first, second)

  // ==========
  // Selector encodings and factory values
  localparam logic [1:0] START_HOT1 = 2'h0;        // First hot start
  localparam logic [1:0] START_HOT2 = 2'h1;        // Second hot start
  localparam logic [1:0] START_COLD = 2'h2;        // Cold start, manual
  localparam logic [1:0] START_STOP = 2'h3;        // Stopped start
  localparam logic [1:0] START_DEFAULT = START_HOT1;

  localparam logic [1:0] EXT_REMOTE  = 2'h0;       // Remote setpoint input
  localparam logic [1:0] EXT_CASCADE = 2'h1;       // Intercontroller cascade
  localparam logic [1:0] EXT_RATIO   = 2'h2;       // Intercontroller ratio setting
  localparam logic [1:0] EXT_DEFAULT = EXT_REMOTE;

  localparam logic [1:0] PROTO_INTERCTL = 2'h2;    // Second port protocol: intercontroller

  localparam logic [1:0] MVX_AUTO     = 2'h0;      // Always use the auto-mode value
  localparam logic [1:0] MVX_DI_PREV  = 2'h1;      // Digital input reuses previous manual value
  localparam logic [1:0] MVX_ALL_PREV = 2'h2;      // Every transfer reuses previous manual value
  localparam logic [1:0] MVX_DEFAULT  = MVX_AUTO;

  localparam logic       TRACK_DEFAULT  = 1'b1;    // Setpoint tracking used
  localparam logic       PVX_DEFAULT    = 1'b0;    // Measured value transfer unused
  localparam logic [4:0] MASTER_DEFAULT = 5'h00;   // Master channel factory value

  // ==========
  // Band default and power interruption ride-through
  localparam int BAND_PERCENT   = 3;               // Band default, percent of span
  localparam int CLOCK_HZ       = 20_000_000;      // System clock rate
  localparam int RIDE_MS        = 20;              // Longest interruption ridden through
  localparam int RIDE_CYCLES    = (CLOCK_HZ / 1000) * RIDE_MS; // Rounded down, longest time

  // ==========
  // Start states
  typedef enum logic [1:0] {
    RUN_STATE_HOT1 = 2'b00,
    RUN_STATE_HOT2 = 2'b01,
    RUN_STATE_COLD = 2'b10,
    RUN_STATE_STOP = 2'b11
  } start_state_t;

  // Power supervisor states
  typedef enum logic [1:0] {
    PWR_UP      = 2'b00,                           // Supply present
    PWR_DOWN    = 2'b01,                           // Supply lost, counting
    PWR_LONG    = 2'b10,                           // Lost beyond ride-through
    PWR_DECIDE  = 2'b11                            // Recovered, pick start state
  } power_state_t;

endpackage : start_mode_pkg

// ### hdl/start_mode_transfer.sv
// Start state selection and operating mode transfer logic
`timescale 1ns/1ns

// What this block does
// RL1: Hold band setting, default three percent span
// RL2: Within band at recovery: first hot start
// RL3: Outside band or zero band: selected start
// RL4: External input: remote, cascade, ratio encodings
// RL5: Cascade/ratio only with intercontroller port ready
// RL6: Master uses remote; slaves cascade or ratio
// RL7: Master channel names master's port address
// RL8: Master channel ignored unless cascade/ratio active
// RL9: Setpoint tracking enable, default used
// RL10: Remote to local copies remote setpoint
// RL11: Selector 0: manual starts from auto value
// RL12: Selector 1: digital input reuses manual value
// RL13: Selector 2: always reuse previous manual value
// RL14: Manual to auto loads measured value setpoint
// RL15: Ride through interruptions up to 20 ms
// RL16: Start selector: hot1, hot2, cold, stop
// RL17: Sample selectors at transfer or recovery
module start_mode_transfer
  import start_mode_pkg::*;
#(
  parameter int WIDTH        = VALUE_W,            // Value width
  parameter int INPUT_SPAN   = 1000,               // Full input span, input units
  parameter int RIDE_COUNT   = RIDE_CYCLES         // Cycles of ride-through, shorten in simulation
) (
  input  wire logic                   clock,
  input  wire logic                   reset,
  // Supply and measurement
  input  wire logic                   power_good,                 // High while supply is present
  input  wire logic signed [WIDTH-1:0] measured_value,
  input  wire logic signed [WIDTH-1:0] remote_setpoint_input,
  input  wire logic [WIDTH-1:0]       manipulated_value_auto_1,   // First manipulated value, auto
  input  wire logic [WIDTH-1:0]       manipulated_value_auto_2,   // Second manipulated value, auto
  input  wire logic [WIDTH-1:0]       manual_adjust_1,            // Operator value in manual mode
  input  wire logic [WIDTH-1:0]       manual_adjust_2,
  // Settings
  input  wire logic [WIDTH-1:0]       band_setting,
  input  wire logic                   band_load,                  // Pulse: load band_setting
  input  wire logic [1:0]             start_mode_select,
  input  wire logic [1:0]             external_input_select,
  input  wire logic                   second_port_ready,
  input  wire logic [1:0]             second_port_protocol_select,
  input  wire logic [ADDR_W-1:0]      master_channel_select,
  input  wire logic                   tracking_enable,
  input  wire logic [1:0]             mv_transfer_select,
  input  wire logic                   pv_transfer_enable,
  // Mode requests (one-cycle pulses)
  input  wire logic                   go_local,
  input  wire logic                   go_remote,
  input  wire logic                   go_manual_digital_input,
  input  wire logic                   go_manual_key,
  input  wire logic                   go_auto,
  input  wire logic signed [WIDTH-1:0] local_setpoint_write,
  input  wire logic                   local_setpoint_load,
  // Results
  output logic [1:0]                  start_state,
  output logic                        start_valid,                // Pulse on recovery decision
  output logic                        link_mode_active,           // Cascade or ratio in force
  output logic [ADDR_W-1:0]           master_address,             // Zero unless link mode
  output logic                        remote_mode,
  output logic                        manual_mode,
  output logic signed [WIDTH-1:0]     set_value,
  output logic [WIDTH-1:0]            first_manipulated_value,
  output logic [WIDTH-1:0]            second_manipulated_value,
  output logic [WIDTH-1:0]            band_value
);

  // ==========
  // Band setting
  // ==========
  localparam logic [WIDTH-1:0] BAND_RESET = WIDTH'((INPUT_SPAN * BAND_PERCENT) / 100);
  localparam logic [WIDTH-1:0] SPAN_MAX   = WIDTH'(INPUT_SPAN);
  localparam int               CNT_W      = $clog2(RIDE_COUNT + 1);
  localparam logic [CNT_W-1:0] RIDE_LAST  = CNT_W'(RIDE_COUNT);

  // Band held, clipped to span; factory value three percent [RL1]
  always_ff @(posedge clock) begin
    if (reset) begin
      // Factory band
      band_value <= BAND_RESET;                     // [RL1]
    end else if (band_load) begin
      // Clip to span
      band_value <= (band_setting > SPAN_MAX) ? SPAN_MAX : band_setting; // [RL1]
    end
  end

  // ==========
  // Power supervisor
  // ==========
  power_state_t       pwr_reg;                      // Supervisor state
  logic [CNT_W-1:0]   down_cnt_reg;                 // Cycles without supply
  logic signed [WIDTH:0] deviation;                 // Measured minus set value
  logic [WIDTH:0]     deviation_abs;                // Magnitude of deviation

  assign deviation     = {measured_value[WIDTH-1], measured_value} - {set_value[WIDTH-1], set_value};
  assign deviation_abs = deviation[WIDTH] ? (WIDTH+1)'(-deviation) : deviation;

  // Counts the outage; short dips return silently [RL15]
  always_ff @(posedge clock) begin
    if (reset) begin
      // Supply taken as present
      pwr_reg      <= PWR_UP;
      down_cnt_reg <= '0;
    end else begin
      case (pwr_reg)
        PWR_UP: begin
          // Idle, counter parked
          down_cnt_reg <= '0;
          if (!power_good) begin
            pwr_reg <= PWR_DOWN;
          end
        end
        PWR_DOWN: begin
          // Time the outage
          if (power_good) begin
            pwr_reg <= PWR_UP;                      // Dip ridden through [RL15]
          end else if (down_cnt_reg >= RIDE_LAST) begin
            pwr_reg <= PWR_LONG;                    // Longer than ride-through [RL15]
          end else begin
            down_cnt_reg <= down_cnt_reg + 1'b1;
          end
        end
        PWR_LONG: begin
          // Wait for supply
          if (power_good) begin
            pwr_reg <= PWR_DECIDE;
          end
        end
        PWR_DECIDE: begin
          // One cycle to decide
          pwr_reg <= PWR_UP;
        end
        default: begin
          pwr_reg <= PWR_UP;
        end
      endcase
    end
  end

  // Start decision, selectors sampled at recovery [RL17]
  always_ff @(posedge clock) begin
    if (reset) begin
      // No decision yet
      start_state <= START_DEFAULT;
      start_valid <= 1'b0;
    end else begin
      // Pulse lasts one cycle
      start_valid <= (pwr_reg == PWR_DECIDE);
      if (pwr_reg == PWR_DECIDE) begin
        if (band_value != '0 && deviation_abs <= {1'b0, band_value}) begin
          start_state <= RUN_STATE_HOT1;            // Within band [RL2]
        end else begin
          case (start_mode_select)                  // Outside band or zero band [RL3]
            START_HOT1: start_state <= RUN_STATE_HOT1; // [RL16]
            START_HOT2: start_state <= RUN_STATE_HOT2;
            START_COLD: start_state <= RUN_STATE_COLD;
            START_STOP: start_state <= RUN_STATE_STOP;
            default:    start_state <= RUN_STATE_HOT1;
          endcase
        end
      end
    end
  end

  // ==========
  // External setpoint source
  // ==========
  logic link_allowed;                               // Port and protocol permit link modes
  assign link_allowed = second_port_ready && (second_port_protocol_select == PROTO_INTERCTL); // [RL5]

  // Link mode only for cascade/ratio on a ready port; remote (0) is master role [RL4] [RL6]
  always_ff @(posedge clock) begin
    if (reset) begin
      // Link off
      link_mode_active <= 1'b0;
      master_address   <= MASTER_DEFAULT;
    end else begin
      // One cycle behind inputs
      link_mode_active <= link_allowed &&
                          (external_input_select == EXT_CASCADE || external_input_select == EXT_RATIO); // [RL4] [RL5]
      if (link_allowed && (external_input_select == EXT_CASCADE || external_input_select == EXT_RATIO)) begin
        master_address <= master_channel_select;   // Names the master [RL7] [RL8]
      end else begin
        master_address <= MASTER_DEFAULT;           // Ignored otherwise [RL8]
      end
    end
  end

  // ==========
  // Remote/local and setpoint
  // ==========
  logic signed [WIDTH-1:0] local_sp_reg;            // Local setpoint

  // Remote/local mode flag
  always_ff @(posedge clock) begin
    if (reset) begin
      // Local after reset
      remote_mode <= 1'b0;
    end else if (go_local) begin
      // Local wins over remote
      remote_mode <= 1'b0;
    end else if (go_remote) begin
      remote_mode <= 1'b1;
    end
  end

  // Local setpoint: tracking copy, measured value substitution, operator write
  always_ff @(posedge clock) begin
    if (reset) begin
      // Cleared
      local_sp_reg <= '0;
    end else if (go_local && remote_mode && tracking_enable) begin
      local_sp_reg <= remote_setpoint_input;        // Tracking copies remote [RL9] [RL10] [RL17]
    end else if (go_auto && manual_mode && pv_transfer_enable && !remote_mode) begin
      local_sp_reg <= measured_value;               // Bumpless return to auto [RL14] [RL17]
    end else if (local_setpoint_load) begin
      // Operator write, lowest priority
      local_sp_reg <= local_setpoint_write;
    end
  end

  // Set value in use; remote takes measured value for one cycle on return to auto, then remote input
  always_ff @(posedge clock) begin
    if (reset) begin
      set_value <= '0;
    end else if (go_auto && manual_mode && pv_transfer_enable) begin
      set_value <= measured_value;                  // [RL14]
    end else begin
      // Follow active source
      set_value <= remote_mode ? remote_setpoint_input : local_sp_reg;
    end
  end

  // ==========
  // Auto/manual and manipulated values
  // ==========
  logic                   go_manual;                // Any manual request
  logic                   reuse_previous;           // Start manual from stored values
  logic [2*WIDTH-1:0]     stored_mv;                // Previous manual session values
  logic [2*WIDTH-1:0]     current_mv;               // Values now in use

  assign go_manual  = go_manual_digital_input || go_manual_key;
  assign current_mv = {second_manipulated_value, first_manipulated_value};
  // Selector read only at the transfer [RL11] [RL12] [RL13] [RL17]
  assign reuse_previous = (mv_transfer_select == MVX_ALL_PREV) ||
                          (mv_transfer_select == MVX_DI_PREV && go_manual_digital_input);

  // Keeps manual values for the next session
  manual_value_store #(
    .WIDTH (WIDTH),
    .DEPTH (MV_CH)
  ) manual_value_store_inst (
    .clock      (clock),
    .reset      (reset),
    .write_en   (manual_mode),
    .write_data (current_mv),
    .read_data  (stored_mv)
  );

  // Auto/manual mode flag
  always_ff @(posedge clock) begin
    if (reset) begin
      manual_mode <= 1'b0;
    end else if (pwr_reg == PWR_DECIDE) begin
      // Restart in auto
      manual_mode <= 1'b0;
    end else if (go_manual) begin
      // Manual wins over auto
      manual_mode <= 1'b1;
    end else if (go_auto) begin
      manual_mode <= 1'b0;
    end
  end

  // Output values: follow auto, seed on entry to manual, then operator
  always_ff @(posedge clock) begin
    if (reset) begin
      // Outputs quiet
      first_manipulated_value  <= '0;
      second_manipulated_value <= '0;
    end else if (!manual_mode && go_manual) begin
      if (reuse_previous) begin
        first_manipulated_value  <= stored_mv[WIDTH-1:0];         // [RL12] [RL13]
        second_manipulated_value <= stored_mv[2*WIDTH-1:WIDTH];
      end else begin
        first_manipulated_value  <= manipulated_value_auto_1;     // [RL11] [RL12]
        second_manipulated_value <= manipulated_value_auto_2;
      end
    end else if (manual_mode) begin
      first_manipulated_value  <= manual_adjust_1;
      second_manipulated_value <= manual_adjust_2;
    end else begin
      first_manipulated_value  <= manipulated_value_auto_1;
      second_manipulated_value <= manipulated_value_auto_2;
    end
  end

endmodule // start_mode_transfer

// ### tb/link_master_model.sv
// Behavioural master controller on the far side of the second port
`timescale 1ns/1ns
module link_master_model
  import start_mode_pkg::*;
#(
  parameter logic [ADDR_W-1:0] OWN_ADDRESS = 5'h03,  // Master's second port address, plain value
  parameter int                LAG         = 2       // Link stages; a new setpoint reaches sp_out LAG+1 edges later
) (
  input  wire logic                      clock,
  input  wire logic                      port_on,    // Port fitted and wired
  input  wire logic                      interctl,   // Intercontroller protocol chosen
  input  wire logic signed [VALUE_W-1:0] master_sp,  // Setpoint the master sends out
  output logic                           ready,
  output logic [1:0]                     protocol,
  output logic [ADDR_W-1:0]              address,
  output logic signed [VALUE_W-1:0]      sp_out
);
  // ==========
  // Link side
  logic signed [VALUE_W-1:0] pipe [LAG];  // Setpoints still in flight

  assign address = OWN_ADDRESS;  // Slaves name this as their master

  // Master runs on remote input and only forwards its own setpoint
  always_ff @(posedge clock) begin
    ready    <= port_on;
    protocol <= interctl ? PROTO_INTERCTL : 2'h1;
    pipe[0]  <= master_sp;
    for (int i = 1; i < LAG; i++) begin
      pipe[i] <= pipe[i-1];
    end
    // Offline word flips, never holds
    sp_out <= port_on ? pipe[LAG-1] : ~sp_out;
  end
endmodule // link_master_model

// ### tb/start_mode_transfer_asserts.sv
// Concurrent checks on the ports of the start and mode transfer logic
`timescale 1ns/1ns
module start_mode_transfer_asserts
  import start_mode_pkg::*;
#(
  parameter int WIDTH      = VALUE_W,     // Value width
  parameter int INPUT_SPAN = 1000,        // Band ceiling
  parameter int RIDE_COUNT = RIDE_CYCLES  // Ride-through length
) (
  input wire logic                    clock,
  input wire logic                    reset,
  input wire logic                    power_good,
  input wire logic signed [WIDTH-1:0] measured_value,
  input wire logic [WIDTH-1:0]        manipulated_value_auto_1,
  input wire logic [WIDTH-1:0]        band_setting,
  input wire logic                    band_load,
  input wire logic [1:0]              external_input_select,
  input wire logic                    second_port_ready,
  input wire logic [1:0]              second_port_protocol_select,
  input wire logic [ADDR_W-1:0]       master_channel_select,
  input wire logic [1:0]              mv_transfer_select,
  input wire logic                    pv_transfer_enable,
  input wire logic                    go_local,
  input wire logic                    go_manual_digital_input,
  input wire logic                    go_manual_key,
  input wire logic                    go_auto,
  input wire logic [1:0]              start_state,
  input wire logic                    start_valid,
  input wire logic                    link_mode_active,
  input wire logic [ADDR_W-1:0]       master_address,
  input wire logic                    remote_mode,
  input wire logic                    manual_mode,
  input wire logic signed [WIDTH-1:0] set_value,
  input wire logic [WIDTH-1:0]        first_manipulated_value,
  input wire logic [WIDTH-1:0]        band_value
);
  // ==========
  // Helper logic
  int   low_cnt;  // Edges seen with the supply lost
  logic link_ok;  // Cascade or ratio may run

  assign link_ok = second_port_ready && second_port_protocol_select == PROTO_INTERCTL &&
                   (external_input_select == EXT_CASCADE || external_input_select == EXT_RATIO);

  // Restarts while supply present
  always_ff @(posedge clock) begin
    low_cnt <= (reset || power_good) ? '0 : low_cnt + 1;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  // Supply back after a dip, or after a real outage
  sequence dip_end;
    $rose(power_good) && low_cnt <= RIDE_COUNT;
  endsequence
  sequence long_end;
    $rose(power_good) && low_cnt > RIDE_COUNT + 1;
  endsequence

  // ==========
  // Properties
  link_on_a: assert property (link_ok |=> link_mode_active && master_address == $past(master_channel_select))
    else $error("link mode or master address not taken");
  link_off_a: assert property (!link_ok |=> !link_mode_active && master_address == 5'h00)
    else $error("master channel used outside link mode");
  band_clip_a: assert property (band_load |=> band_value ==
    (($past(band_setting) > INPUT_SPAN) ? WIDTH'(INPUT_SPAN) : $past(band_setting)))
    else $error("band value not loaded or not clipped");
  local_wins_a: assert property (go_local |=> !remote_mode)
    else $error("local request did not leave remote mode");
  key_entry_a: assert property (!manual_mode && go_manual_key && !go_manual_digital_input && power_good &&
    mv_transfer_select != MVX_ALL_PREV |=> manual_mode && first_manipulated_value == $past(manipulated_value_auto_1))
    else $error("key entry did not start from the auto value");
  pv_load_a: assert property (manual_mode && go_auto && !go_manual_key && !go_manual_digital_input &&
    pv_transfer_enable |=> !manual_mode && set_value == $past(measured_value))
    else $error("measured value not loaded on return to auto");
  ride_through_a: assert property (dip_end |-> !start_valid [*4])
    else $error("short dip produced a start decision");
  wake_start_a: assert property (long_end |-> ##[0:3] start_valid)
    else $error("outage gave no start decision");
  start_hold_a: assert property (start_valid |=> !start_valid && $stable(start_state))
    else $error("start decision not a held single pulse");
endmodule // start_mode_transfer_asserts

bind start_mode_transfer start_mode_transfer_asserts #(.WIDTH(WIDTH), .INPUT_SPAN(INPUT_SPAN),
  .RIDE_COUNT(RIDE_COUNT)) start_mode_transfer_asserts_inst (.*);

// ### tb/test_start_mode_transfer.sv
// Self-checking bench for the start and mode transfer logic
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch at %0t got %h expected %h", $time, (g), (e)); end end
module test_start_mode_transfer import start_mode_pkg::*;;
  // ==========
  // Signals
  localparam int RIDE = 10;    // Short ride-through keeps the run brief
  localparam int SPAN = 1000;  // Input span handed to the design
  logic clock = 1'b0, reset = 1'b1, power_good = 1'b1, port_on = 1'b1, interctl = 1'b1;
  logic tracking_enable = TRACK_DEFAULT, pv_transfer_enable = PVX_DEFAULT;
  logic [1:0] start_mode_select = START_DEFAULT, external_input_select = EXT_DEFAULT;
  logic [1:0] mv_transfer_select = MVX_DEFAULT, second_port_protocol_select, start_state;
  logic [4:0] master_channel_select = MASTER_DEFAULT, mcs, address, master_address;
  logic [6:0] req = 7'h00;  // One bit per request pulse
  logic [15:0] band_setting = 16'h0000, measured_value = 16'h0000, local_setpoint_write = 16'h0000;
  logic [15:0] manipulated_value_auto_1 = 16'h0000, manipulated_value_auto_2 = 16'h0000;
  logic [15:0] manual_adjust_1 = 16'h0000, manual_adjust_2 = 16'h0000, master_sp = 16'h0000;
  logic [15:0] remote_setpoint_input, set_value, first_manipulated_value, second_manipulated_value;
  logic [15:0] band_value, sv, bands [3] = '{16'h0000, 16'h07D0, 16'h0032};
  logic start_valid, link_mode_active, remote_mode, manual_mode, second_port_ready, on;
  wire go_local = req[0], go_remote = req[1], go_manual_digital_input = req[2], go_manual_key = req[3];
  wire go_auto = req[4], local_setpoint_load = req[5], band_load = req[6];
  logic [31:0] got, want, a, m, mprev, wakes = 32'h0;
  logic [3:0] sel;
  logic [7:0] look_seq = 8'h00, seen = 8'h00;  // Notes posted and notes judged
  logic [35:0] notes [$];                       // Expected results, oldest first
  int fail_count = 0, n_compared = 0;
  int devs [7] = '{50, -50, 51, -51, -51, 51, 0}, modes [7] = '{3, 2, 1, 3, 2, 0, 2};

  always #25 clock = ~clock;

  start_mode_transfer #(.INPUT_SPAN(SPAN), .RIDE_COUNT(RIDE)) start_mode_transfer_inst (.*);
  link_master_model link_master_model_inst (
    .clock    (clock),
    .port_on  (port_on),
    .interctl (interctl),
    .master_sp(master_sp),
    .ready    (second_port_ready),
    .protocol (second_port_protocol_select),
    .address  (address),
    .sp_out   (remote_setpoint_input)
  );

  // ==========
  // Tasks
  task automatic tick(int n);
    repeat (n) @(posedge clock);
  endtask
  // Request high for one cycle; returns at the edge that takes it
  task automatic pulse(int b);
    @(posedge clock) req[b] <= 1'b1;
    @(posedge clock) req <= 7'h00;
  endtask
  // Post an expectation; the watcher judges the outputs of this edge
  task automatic note(logic [3:0] s, logic [31:0] e);
    notes.push_back({s, e});
    look_seq <= look_seq + 8'h01;
    @(posedge clock);
  endtask
  task automatic outage(int n);
    power_good <= 1'b0;
    tick(n);
    power_good <= 1'b1;
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========
  // Watchers
  // Decisions counted, since the pulse itself lasts one cycle
  always @(posedge clock) if (start_valid === 1'b1) wakes <= wakes + 32'h1;
  // Judge notes mid-cycle, outputs settled
  always @(negedge clock) begin
    while (seen != look_seq) begin
      {sel, want} = notes.pop_front();
      case (sel)
        4'h0: got = {16'h0000, set_value};
        4'h1: got = {first_manipulated_value, second_manipulated_value};
        4'h2: got = {16'h0000, band_value};
        4'h3: got = {30'h0, start_state};
        4'h4: got = {26'h0, link_mode_active, master_address};
        default: got = wakes;
      endcase
      `CHK(got, want)
      seen = seen + 8'h01;
    end
  end
  // Whole run needs about 340 cycles
  initial begin
    tick(5000);
    fail_count++;
    print_verdict();
  end

  // ==========
  // Main sequence
  initial begin
    void'($urandom(88514));
    tick(4);
    reset <= 1'b0;
    note(4'h2, 32'h1E);  // Band factory value
    note(4'h3, 32'h0);   // Start state after reset
    foreach (bands[i]) begin
      band_setting <= bands[i];
      pulse(6);
      note(4'h2, (bands[i] > SPAN) ? SPAN : bands[i]);  // Zero and clipping
    end
    // Every input type against port readiness and protocol
    for (int k = 0; k < 12; k++) begin
      mcs = (k == 11) ? address : 5'($urandom());
      on = k % 3 != 0 && (k / 3) % 2 == 1 && k >= 6;
      external_input_select <= 2'(k % 3);
      port_on <= (k / 3) % 2 == 1;
      interctl <= k >= 6;
      master_channel_select <= mcs;
      tick(3);
      note(4'h4, {26'h0, on, on ? mcs : 5'h00});
    end
    external_input_select <= EXT_REMOTE;
    local_setpoint_write <= 16'h0100;
    pulse(5);
    // Tracking used, then unused: local keeps the first copy
    for (int t = 0; t < 2; t++) begin
      master_sp <= t ? 16'h0300 : 16'h0200;
      tracking_enable <= !t;
      pulse(1);
      tick(4);
      pulse(0);
      tick(2);
      note(4'h0, 32'h0200);
    end
    sv = 16'h0200;
    mprev = 32'h0;
    // Each selector with digital input and key entries
    for (int k = 0; k < 6; k++) begin
      a = $urandom();
      m = $urandom();
      {manipulated_value_auto_1, manipulated_value_auto_2} <= a;
      {manual_adjust_1, manual_adjust_2} <= m;
      mv_transfer_select <= 2'(k / 2);
      pulse(2 + k % 2);
      mv_transfer_select <= 2'((k / 2 + 1) % 3);  // Late change must not count
      note(4'h1, (k / 2 == 2 || k == 2) ? mprev : a);
      tick(2);
      note(4'h1, m);  // Operator values while manual
      mprev = m;
      measured_value <= 16'($urandom_range(400, 900));
      pv_transfer_enable <= k % 3 != 1;
      pulse(4);
      if (k % 3 != 1) sv = measured_value;
      tick(2);
      note(4'h0, {16'h0000, sv});
    end
    outage(RIDE);
    tick(6);
    note(4'hF, 32'h0);  // Short dip ridden through
    // Band edges on both sides, then a zero band
    foreach (devs[k]) begin
      band_setting <= (k == 6) ? 16'h0000 : 16'h0032;
      pulse(6);
      start_mode_select <= 2'(modes[k]);
      measured_value <= 16'(sv + devs[k]);
      outage(RIDE + 4);
      tick(6);
      note(4'h3, (k < 2) ? 32'h0 : modes[k]);
      note(4'hF, k + 1);
    end
    print_verdict();
  end
endmodule // test_start_mode_transfer
